// file: rtl/dual_select_map.svh
// Offsets, field positions and reset values of the dual channel host select block.
`ifndef DUAL_SELECT_MAP_SVH
`define DUAL_SELECT_MAP_SVH

// Number of channels and registers per channel.
`define DS_CHANNELS        2
`define DS_REGS_PER_CHAN   8

// Offset of the read-only modem status register in each channel.
`define DS_MODEM_STATUS_OFS 3'h6

// Field positions inside the modem status register.
`define DS_MSR_DELTA_CTS   0
`define DS_MSR_DELTA_CD    3
`define DS_MSR_CTS         4
`define DS_MSR_CD          7

// Offset and bit of the modem interrupt enable in each channel.
`define DS_INT_ENABLE_OFS  3'h1
`define DS_INT_MODEM_BIT   3

// Reset value of every register.
`define DS_REG_RESET       8'h00

// Width of the pin synchroniser bundle.
`define DS_SYNC_WIDTH      18

`endif

// file: rtl/dual_select_pkg.sv
// Types shared by the dual channel host select block.
package dual_select_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [2:0] regIdx_t;
    typedef logic [1:0][7:0][7:0] regFile_t;
endpackage : dual_select_pkg

// file: rtl/pin_sync2.sv
// Two flip-flop synchroniser for a bundle of asynchronous pins.
`timescale 1ns/1ps
module pin_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    // Pins in, synchronised copies out.
    input  wire logic [WIDTH-1:0] pinAsync,
    output logic      [WIDTH-1:0] pinSync
);
    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;

    // The first stage feeds only the second; reset to idle-high pins.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            stage1_r <= '1;
            stage2_r <= '1;
        end else begin
            stage1_r <= pinAsync;
            stage2_r <= stage1_r;
        end
    end

    assign pinSync = stage2_r;
endmodule : pin_sync2

// file: rtl/dual_channel_host_select.sv
// Host port decode and modem status of a dual channel serial device.
//
// Function
// - The three low address bits pick which register of the chosen channel is reached.
// - The channel pick bit sends low accesses to the first channel and high ones to the second.
// - Transfers happen only while the active-low device select is low, to the picked channel.
// - Each channel has an active-low carrier input whose low level means carrier present.
// - Each channel reports its active-low clear-to-send input in bit 4 of its modem status.
// - Clear-to-send is readable status and a modem interrupt source, and changes no other register behaviour.
// - A low read/write line writes the data bus to the register, a high one reads it out.
// - The data bus is eight bits, bit 0 least significant, and floats when not driven.
// - Both channels' interrupts merge onto one active-low open-drain request pin.
`timescale 1ns/1ps
`include "dual_select_map.svh"
module dual_channel_host_select
    import dual_select_pkg::*;
(
    // Clock and reset.
    input  wire logic   ref_clk,
    input  wire logic   resetn,
    // Processor bus pins.
    input  wire logic   selectN,
    input  wire logic   reg_sel_bit0,
    input  wire logic   reg_sel_bit1,
    input  wire logic   reg_sel_bit2,
    input  wire logic   channel_pick,
    input  wire logic   readNotWrite,
    input  wire byte_t  dataIn,
    output byte_t       dataOut,
    output logic        dataDriveN,
    // Modem status pins.
    input  wire logic   carrier_present_first_n,
    input  wire logic   carrier_present_second_n,
    input  wire logic   clear_to_send_first_n,
    input  wire logic   clear_to_send_second_n,
    // Open-drain interrupt request.
    output logic        irqOut,
    output logic        irqDriveN
);
    logic [`DS_SYNC_WIDTH-1:0] pinBundle;
    logic [`DS_SYNC_WIDTH-1:0] pinSync;
    logic                      selS;
    regIdx_t                   regS;
    logic                      chanS;
    logic                      rdS;
    byte_t                     dataS;
    logic [1:0]                cdS;
    logic [1:0]                ctsS;

    logic                      selPrev_r;
    logic                      wrStrobe;
    logic                      rdStart;
    regFile_t                  regs_r;
    regFile_t                  regs_nxt;
    logic [1:0]                ctsPrev_r;
    logic [1:0]                cdPrev_r;
    logic [1:0]                deltaCts_r;
    logic [1:0]                deltaCts_nxt;
    logic [1:0]                deltaCd_r;
    logic [1:0]                deltaCd_nxt;
    byte_t                     modem_status_reg [2];
    logic [1:0]                chanIrq;
    byte_t                     readMux;
    byte_t                     dataOut_r;
    byte_t                     dataOut_nxt;
    logic                      dataDriveN_r;
    logic                      dataDriveN_nxt;
    logic                      irqDriveN_r;

    // Every pin is asynchronous to ref_clk, so all pass the two-stage synchroniser.
    // The two stages cost two cycles of latency on every access, which is why the processor
    // must hold its pins steady for three cycles before and during the select low time.
    assign pinBundle = {selectN, reg_sel_bit2, reg_sel_bit1, reg_sel_bit0, channel_pick,
                        readNotWrite, dataIn, carrier_present_second_n,
                        carrier_present_first_n, clear_to_send_second_n,
                        clear_to_send_first_n};

    pin_sync2 #(.WIDTH(`DS_SYNC_WIDTH)) u_sync (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .pinAsync (pinBundle),
        .pinSync  (pinSync)
    );

    assign {selS, regS, chanS, rdS, dataS, cdS, ctsS} = pinSync;

    // Returns true when the offset names the read-only modem status register.
    function automatic logic isModemStatus(input regIdx_t idx);
        return idx == `DS_MODEM_STATUS_OFS;
    endfunction : isModemStatus

    // An access starts on the first synchronised cycle with the select low.
    assign wrStrobe = !selS && selPrev_r && !rdS;
    assign rdStart  = !selS && selPrev_r && rdS;

    // Modem status per channel; inputs are inverted so a set bit means asserted.
    generate
        for (genvar c = 0; c < `DS_CHANNELS; c++) begin : g_msr
            always_comb begin
                modem_status_reg[c]                     = 8'h00;
                modem_status_reg[c][`DS_MSR_CD]         = !cdS[c];
                modem_status_reg[c][`DS_MSR_CTS]        = !ctsS[c];
                modem_status_reg[c][`DS_MSR_DELTA_CD]   = deltaCd_r[c];
                modem_status_reg[c][`DS_MSR_DELTA_CTS]  = deltaCts_r[c];
            end
            assign chanIrq[c] = regs_r[c][`DS_INT_ENABLE_OFS][`DS_INT_MODEM_BIT] &&
                                (deltaCd_r[c] || deltaCts_r[c]);
        end
    endgenerate

    // Register writes; the modem status offset holds no storage and ignores writes.
    always_comb begin
        regs_nxt = regs_r;
        if (wrStrobe && !isModemStatus(regS)) begin
            regs_nxt[chanS][regS] = dataS;
        end
    end

    // Delta flags: a new edge wins over the clear done by reading modem status.
    always_comb begin
        deltaCts_nxt = deltaCts_r;
        deltaCd_nxt  = deltaCd_r;
        if (rdStart && isModemStatus(regS)) begin
            deltaCts_nxt[chanS] = 1'b0;
            deltaCd_nxt[chanS]  = 1'b0;
        end
        deltaCts_nxt = deltaCts_nxt | (ctsS ^ ctsPrev_r);
        deltaCd_nxt  = deltaCd_nxt | (cdS ^ cdPrev_r);
    end

    // Read data selection and bus drive; the bus floats whenever the select is high.
    // The status offset shows live synchronised pin levels, so a read that races a pin
    // change may return either level; the delta flags keep the change for the next read.
    always_comb begin
        readMux        = isModemStatus(regS) ? modem_status_reg[chanS] : regs_r[chanS][regS];
        dataOut_nxt    = dataOut_r;
        dataDriveN_nxt = 1'b1;
        if (!selS && rdS) begin
            dataOut_nxt    = readMux;
            dataDriveN_nxt = 1'b0;
        end
    end

    // State registers.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            selPrev_r    <= 1'b1;
            regs_r       <= {`DS_CHANNELS*`DS_REGS_PER_CHAN{`DS_REG_RESET}};
            ctsPrev_r    <= 2'h3;
            cdPrev_r     <= 2'h3;
            deltaCts_r   <= 2'h0;
            deltaCd_r    <= 2'h0;
            dataOut_r    <= 8'h00;
            dataDriveN_r <= 1'b1;
            irqDriveN_r  <= 1'b1;
        end else begin
            selPrev_r    <= selS;
            regs_r       <= regs_nxt;
            ctsPrev_r    <= ctsS;
            cdPrev_r     <= cdS;
            deltaCts_r   <= deltaCts_nxt;
            deltaCd_r    <= deltaCd_nxt;
            dataOut_r    <= dataOut_nxt;
            dataDriveN_r <= dataDriveN_nxt;
            irqDriveN_r  <= !(|chanIrq);
        end
    end

    // Open-drain pin: only ever pulls low, the board pull-up makes the high level.
    assign irqOut     = 1'b0;
    assign irqDriveN  = irqDriveN_r;
    assign dataOut    = dataOut_r;
    assign dataDriveN = dataDriveN_r;

    // Checks on the bus, status and interrupt behaviour.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    bus_floats_idle_a: assert property (selS |=> dataDriveN)
        else $error("Data bus driven while deselected.");
    bus_drives_read_a: assert property (!selS && rdS |=> !dataDriveN)
        else $error("Data bus not driven during a read.");
    write_lands_a: assert property (wrStrobe && !isModemStatus(regS)
        |=> regs_r[$past(chanS)][$past(regS)] == $past(dataS))
        else $error("Write data did not land in the addressed register.");
    other_chan_kept_a: assert property (wrStrobe
        |=> regs_r[!$past(chanS)] == $past(regs_r[!chanS]))
        else $error("Write disturbed the other channel.");
    cts_status_a: assert property (rdStart && isModemStatus(regS) && !chanS
        |=> dataOut[`DS_MSR_CTS] == !$past(ctsS[0]))
        else $error("Clear-to-send status bit wrong.");
    cts_second_a: assert property (rdStart && isModemStatus(regS) && chanS
        |=> dataOut[`DS_MSR_CTS] == !$past(ctsS[1]))
        else $error("Second channel clear-to-send status bit wrong.");
    carrier_status_a: assert property ($fell(cdS[0]) |-> ##1 modem_status_reg[0][`DS_MSR_CD]
        && deltaCd_r[0])
        else $error("Carrier presence not reported.");
    cts_no_effect_a: assert property (!wrStrobe && $changed(ctsS) |=> $stable(regs_r))
        else $error("Clear-to-send changed a register.");
    read_data_a: assert property (!selS && rdS ##1 !selS && rdS
        |-> dataOut_r == $past(readMux))
        else $error("Read data does not match the addressed register.");
    irq_merge_a: assert property (|chanIrq |=> !irqDriveN ##0 !irqOut)
        else $error("Interrupt request not asserted.");

    // Storage, delta and release checks that a broken decode or flag path would trip.
    deselect_no_write_a: assert property (selS |=> $stable(regs_r))
        else $error("Register changed while deselected.");
    status_no_store_a: assert property (regs_r[0][`DS_MODEM_STATUS_OFS] == `DS_REG_RESET
        && regs_r[1][`DS_MODEM_STATUS_OFS] == `DS_REG_RESET)
        else $error("Modem status offset took a write.");
    cd_delta_set_a: assert property ($changed(cdS[1]) |=> deltaCd_r[1])
        else $error("Second channel carrier change not flagged.");
    cts_delta_set_a: assert property ($changed(ctsS[0]) |=> deltaCts_r[0])
        else $error("First channel clear-to-send change not flagged.");
    irq_release_a: assert property (!(|chanIrq) |=> irqDriveN)
        else $error("Interrupt request held without a cause.");

    write_seen_c: cover property (wrStrobe ##[1:20] rdStart);
    status_read_c: cover property (rdStart && isModemStatus(regS) && chanS);
    irq_seen_c: cover property ($fell(irqDriveN));
    cts_change_c: cover property ($changed(ctsS));
endmodule : dual_channel_host_select

// file: verif/cpu_model.sv
// Processor bus model that drives the host port pins one access at a time.
`timescale 1ns/1ps
module cpu_model
    import dual_select_pkg::*;
(
    // Clock.
    input  wire logic ref_clk,
    // Bus pins toward the device.
    output logic      selectN,
    output regIdx_t   regIdx,
    output logic      channel_pick,
    output logic      readNotWrite,
    output byte_t     dataIn
);
    // Idle bus is deselected.
    initial begin
        selectN = 1'b1;
        regIdx = 3'h0;
        channel_pick = 1'b0;
        readNotWrite = 1'b1;
        dataIn = 8'h00;
    end

    // Pins settle three cycles before select, which is held five cycles, then a four cycle gap.
    task automatic access(input logic rd, input logic ch, input regIdx_t ofs, input byte_t d);
        @(negedge ref_clk);
        regIdx = ofs;
        channel_pick = ch;
        readNotWrite = rd;
        dataIn = rd ? ~dataIn : d;
        repeat (3) @(negedge ref_clk);
        selectN = 1'b0;
        repeat (5) @(negedge ref_clk);
        selectN = 1'b1;
        dataIn = ~dataIn; // Released data shows the inverse so stale bytes never match.
        repeat (4) @(negedge ref_clk);
    endtask : access

    // Wiggles every qualifier while deselected, a write that must go nowhere.
    task automatic wiggle(input byte_t d);
        for (int i = 0; i < 8; i++) begin
            @(negedge ref_clk);
            regIdx = 3'(i);
            channel_pick = i[0];
            readNotWrite = i[1];
            dataIn = d ^ 8'(i);
        end
    endtask : wiggle
endmodule : cpu_model

// file: verif/tb_top.sv
// Self-checking bench of the dual channel host select block.
`timescale 1ns/1ps
module tb_top
    import dual_select_pkg::*;
;
    logic       ref_clk = 1'b0;
    logic       resetn = 1'b0;
    logic       selectN, channel_pick, readNotWrite, dataDriveN, irqOut, irqDriveN;
    regIdx_t    regIdx;
    byte_t      dataIn, dataOut;
    logic [1:0] cdN = 2'b11;
    logic [1:0] ctsN = 2'b11;
    logic       prevDrive = 1'b1;
    byte_t      shadow [2][8];
    byte_t      expQ [$];
    byte_t      maskQ [$];
    int         error_cnt = 0;
    int         n_tests = 0;

    // Clock of 5 ns period.
    always #2.5 ref_clk = ~ref_clk;

    cpu_model cpu (.ref_clk(ref_clk), .selectN(selectN), .regIdx(regIdx),
        .channel_pick(channel_pick), .readNotWrite(readNotWrite), .dataIn(dataIn));

    dual_channel_host_select uut (.ref_clk(ref_clk), .resetn(resetn), .selectN(selectN),
        .reg_sel_bit0(regIdx[0]), .reg_sel_bit1(regIdx[1]), .reg_sel_bit2(regIdx[2]),
        .channel_pick(channel_pick), .readNotWrite(readNotWrite), .dataIn(dataIn),
        .dataOut(dataOut), .dataDriveN(dataDriveN),
        .carrier_present_first_n(cdN[0]), .carrier_present_second_n(cdN[1]),
        .clear_to_send_first_n(ctsN[0]), .clear_to_send_second_n(ctsN[1]),
        .irqOut(irqOut), .irqDriveN(irqDriveN));

    task automatic check(input byte_t got, input byte_t exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic summarize();
        $display("mismatches=%0d checks=%0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    task automatic wr(input logic ch, input regIdx_t ofs, input byte_t d);
        if (ofs != 3'h6)
            shadow[ch][ofs] = d;
        cpu.access(1'b0, ch, ofs, d);
    endtask : wr

    task automatic rd(input logic ch, input regIdx_t ofs, input byte_t e, input byte_t m);
        expQ.push_back(e & m);
        maskQ.push_back(m);
        cpu.access(1'b1, ch, ofs, 8'h00);
    endtask : rd

    // Modem status as seen by the processor, with the chosen delta flags.
    function automatic byte_t stat(input logic ch, input logic dcd, input logic dcts);
        return {~cdN[ch], 2'b00, ~ctsN[ch], dcd, 2'b00, dcts};
    endfunction : stat

    // Each new drive of the bus takes the oldest expectation off the queue.
    always @(negedge ref_clk) begin
        prevDrive <= dataDriveN;
        if (prevDrive === 1'b1 && dataDriveN === 1'b0) begin
            if (expQ.size() == 0)
                check({7'h0, dataDriveN}, 8'h01);
            else
                check(dataOut & maskQ.pop_front(), expQ.pop_front());
        end
    end

    // Main sequence.
    initial begin
        void'($urandom(73679));
        repeat (20) @(negedge ref_clk);
        check({6'h0, dataDriveN, irqDriveN}, 8'h03);
        resetn = 1'b1;
        rd(0, 3'h6, 8'h00, 8'hFF);
        rd(1, 3'h6, 8'h00, 8'hFF);
        for (int c = 0; c < 2; c++)
            for (int o = 0; o < 8; o++)
                wr(c[0], 3'(o), 8'($urandom));
        for (int c = 0; c < 2; c++)
            for (int o = 0; o < 8; o++)
                rd(c[0], 3'(o), (o == 6) ? 8'h00 : shadow[c][o], 8'hFF);
        cpu.wiggle(~shadow[0][0]);
        check({7'h0, dataDriveN}, 8'h01);
        rd(0, 3'h0, shadow[0][0], 8'hFF);
        @(negedge ref_clk);
        cdN[0] = 1'b0;
        ctsN[1] = 1'b0;
        repeat (6) @(negedge ref_clk);
        rd(0, 3'h6, stat(0, 1'b1, 1'b0), 8'hFF);
        rd(1, 3'h6, stat(1, 1'b0, 1'b1), 8'hFF);
        rd(0, 3'h6, stat(0, 1'b0, 1'b0), 8'hFF);
        rd(1, 3'h6, stat(1, 1'b0, 1'b0), 8'hFF);
        rd(1, 3'h0, shadow[1][0], 8'hFF);
        for (int c = 0; c < 2; c++) begin
            wr(c[0], 3'h1, 8'h08);
            for (int k = 0; k < 2; k++) begin
                check({7'h0, irqDriveN}, 8'h01);
                if (k == 0)
                    cdN[c] = ~cdN[c];
                else
                    ctsN[c] = ~ctsN[c];
                for (int i = 0; i < 10 && irqDriveN !== 1'b0; i++)
                    @(negedge ref_clk);
                check({6'h0, irqDriveN, irqOut}, 8'h00);
                rd(c[0], 3'h6, stat(c[0], k == 0, k == 1), 8'hFF);
            end
            check({7'h0, irqDriveN}, 8'h01);
            wr(c[0], 3'h1, 8'h00);
        end
        check(8'(expQ.size()), 8'h00);
        summarize();
    end

    // Watchdog well beyond the roughly seven hundred cycles the sequence needs.
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        summarize();
    end
endmodule : tb_top
